// *** hw/phy_mgmt_regs.v ***
`timescale 1ns/1ps
`default_nettype none

`include "phy_mgmt_regs.vh"

// How it works
// - reset pin low at least 160 us
// - pin reset restores defaults, relatches straps
// - pin reset honoured at any time
// - writing control bit 15 starts software reset
// - software reset bit clears itself when done
// - software reset lasts about 160 us
// - software reset restores defaults, relatches straps
// - control register fields at offset 00h
// - read-only status register at offset 01h
// - identifier registers at 02h and 03h
// - advertisement 04h and partner base page 05h
// - partner next page shown at 05h
// - next page transmit register at 07h
// - extended registers at 10h to 1Bh
module phy_mgmt_regs #(
  parameter SW_RESET_CYCLES = `SW_RESET_US * `CLK_MHZ,
  // arbitrary identity values
  parameter [15:0] OUI_HIGH  = 16'h1234,
  parameter [5:0]  OUI_LOW   = 6'h15,
  parameter [5:0]  MODEL_NUM = 6'h0A,
  parameter [3:0]  MODEL_REV = 4'h1
) (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  input  wire        reset_pin_n,
  // management pins
  input  wire        mdc,
  input  wire        mdio_in,
  output wire        mdio_out,
  output wire        mdio_oe_n,
  // strap pins
  input  wire [4:0]  strap_phy_addr,
  input  wire        strap_an_enable,
  input  wire        strap_speed,
  input  wire        strap_duplex,
  // state from the datapath, same clock
  input  wire        an_complete,
  input  wire        remote_fault,
  input  wire        link_up,
  input  wire        jabber,
  input  wire [4:0]  expansion_bits,
  input  wire [15:0] partner_page,
  input  wire        partner_page_stb,
  input  wire [15:0] link_summary,
  input  wire        polarity_inv,
  input  wire        false_carrier_evt,
  input  wire        rx_error_evt,
  // configuration to the datapath
  output wire        core_rst,
  output reg  [15:0] basic_mode_control_q,
  output reg         an_restart_q,
  output reg  [15:0] negotiation_advertise_q,
  output reg  [15:0] next_page_transmit_q,
  output reg  [15:0] coding_sublayer_config_q,
  output reg  [15:0] transceiver_control_q,
  output reg  [15:0] ten_base_status_control_q,
  output reg  [15:0] driver_test_control_q
);

  reg  [7:0]  strap_s1_q;
  reg  [7:0]  strap_s2_q;
  reg  [7:0]  strap_lat_q;
  reg  [15:0] partner_ability_q;
  reg  [7:0]  false_carrier_q;
  reg  [7:0]  receive_error_q;
  reg         link_ll_q;
  reg         jabber_lh_q;
  reg         remote_lh_q;
  reg  [15:0] rd_data;
  wire [4:0]  reg_addr;
  wire [15:0] wr_data;
  wire        wr_stb;
  wire        rd_stb;
  wire        sw_busy;
  wire        sw_req;
  wire        rd_status;
  wire [15:0] status_word;

  // merge a write into a register through its writable mask
  function [15:0] masked;
    input [15:0] old_val;
    input [15:0] new_val;
    input [15:0] mask;
    begin
      masked = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  // saturating clear-on-read event counter; an event wins over the clear
  function [7:0] count_step;
    input [7:0] cur;
    input       evt;
    input       clr;
    begin
      if (clr)
        count_step = evt ? 8'h01 : 8'h00;
      else if (evt && cur != `COUNTER_MAX)
        count_step = cur + 8'h01;
      else
        count_step = cur;
    end
  endfunction

  // ****************************************
  // reset control and serial engine
  // ****************************************
  assign sw_req = wr_stb && reg_addr == `OFS_BASIC_MODE_CONTROL &&
                  wr_data[`CTL_RESET_BIT];

  reset_ctl #(
    .SW_RESET_CYCLES (SW_RESET_CYCLES)
  ) u_reset_ctl (
    .clk         (clk),
    .srst        (srst),
    .reset_pin_n (reset_pin_n),
    .sw_req      (sw_req),
    .core_rst_q  (core_rst),
    .sw_busy_q   (sw_busy)
  );

  mdio_serial u_mdio_serial (
    .clk         (clk),
    .rst         (core_rst),
    .mdc         (mdc),
    .mdio_in     (mdio_in),
    .mdio_out_q  (mdio_out),
    .mdio_oe_n_q (mdio_oe_n),
    .phy_addr    (strap_lat_q[7:3]),
    .rd_data     (rd_data),
    .reg_addr_q  (reg_addr),
    .wr_data_q   (wr_data),
    .wr_stb_q    (wr_stb),
    .rd_stb_q    (rd_stb)
  );

  // ****************************************
  // strap capture
  // ****************************************
  // straps follow the pins for as long as reset holds, so the
  // value kept is the one present at release
  always @(posedge clk) begin
    strap_s1_q <= {strap_phy_addr, strap_an_enable, strap_speed,
                   strap_duplex};
    strap_s2_q <= strap_s1_q;
    if (core_rst)
      strap_lat_q <= strap_s2_q;
  end

  // ****************************************
  // writable registers
  // ****************************************
  always @(posedge clk) begin
    if (core_rst) begin
      basic_mode_control_q      <= 16'h0000;
      basic_mode_control_q[`CTL_SPEED_BIT]     <= strap_s2_q[1];
      basic_mode_control_q[`CTL_AN_ENABLE_BIT] <= strap_s2_q[2];
      basic_mode_control_q[`CTL_DUPLEX_BIT]    <= strap_s2_q[0];
      an_restart_q              <= 1'b0;
      negotiation_advertise_q   <= `ADVERTISE_RST;
      next_page_transmit_q      <= `NEXT_PAGE_RST;
      partner_ability_q         <= `PARTNER_RST;
      coding_sublayer_config_q  <= `CODING_CFG_RST;
      transceiver_control_q     <= `XCVR_CTRL_RST;
      ten_base_status_control_q <= `TEN_BASE_RST;
      driver_test_control_q     <= `DRV_TEST_RST;
    end else begin
      an_restart_q <= 1'b0;
      if (partner_page_stb)
        partner_ability_q <= partner_page;
      if (wr_stb) begin
        case (reg_addr)
          `OFS_BASIC_MODE_CONTROL: begin
            // reset and restart act as pulses and are not stored
            basic_mode_control_q <= {1'b0, wr_data[14:10], 1'b0,
                                     wr_data[8:7], 7'h00};
            an_restart_q <= wr_data[`CTL_AN_RESTART_BIT];
          end
          `OFS_NEG_ADVERTISE:
            negotiation_advertise_q <= masked(negotiation_advertise_q,
              wr_data, `ADVERTISE_MASK);
          `OFS_PARTNER_ABILITY:
            partner_ability_q <= wr_data;
          `OFS_NEXT_PAGE_TRANSMIT:
            next_page_transmit_q <= masked(next_page_transmit_q,
              wr_data, `NEXT_PAGE_MASK);
          `OFS_CODING_SUBLAYER_CFG:
            coding_sublayer_config_q <= masked(coding_sublayer_config_q,
              wr_data, `CODING_CFG_MASK);
          `OFS_TRANSCEIVER_CONTROL:
            transceiver_control_q <= masked(transceiver_control_q,
              wr_data, `XCVR_CTRL_MASK);
          `OFS_TEN_BASE_STAT_CTRL:
            ten_base_status_control_q <= masked(
              ten_base_status_control_q, wr_data, `TEN_BASE_MASK);
          `OFS_DRIVER_TEST_CONTROL:
            driver_test_control_q <= masked(driver_test_control_q,
              wr_data, `DRV_TEST_MASK);
          default: begin
            // read-only and reserved offsets drop the write
            an_restart_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // latched status and counters
  // ****************************************
  assign rd_status = rd_stb && reg_addr == `OFS_BASIC_MODE_STATUS;

  always @(posedge clk) begin
    if (core_rst) begin
      link_ll_q       <= 1'b0;
      jabber_lh_q     <= 1'b0;
      remote_lh_q     <= 1'b0;
      false_carrier_q <= 8'h00;
      receive_error_q <= 8'h00;
    end else begin
      // a loss of link in the read cycle still latches low
      link_ll_q   <= link_up & (link_ll_q | rd_status);
      jabber_lh_q <= jabber | (jabber_lh_q & ~rd_status);
      remote_lh_q <= remote_fault | (remote_lh_q & ~rd_status);
      false_carrier_q <= count_step(false_carrier_q, false_carrier_evt,
        rd_stb && reg_addr == `OFS_FALSE_CARRIER_CNT);
      receive_error_q <= count_step(receive_error_q, rx_error_evt,
        rd_stb && reg_addr == `OFS_RECEIVE_ERROR_CNT);
    end
  end

  assign status_word = `STS_FIXED_CAPS |
    ({15'h0000, an_complete} << `STS_AN_COMPLETE_BIT) |
    ({15'h0000, remote_lh_q} << `STS_REMOTE_FLT_BIT) |
    ({15'h0000, link_ll_q}   << `STS_LINK_BIT) |
    ({15'h0000, jabber_lh_q} << `STS_JABBER_BIT);

  // ****************************************
  // read decode
  // ****************************************
  always @* begin
    rd_data = 16'h0000;
    case (reg_addr)
      `OFS_BASIC_MODE_CONTROL:
        rd_data = basic_mode_control_q |
                  ({15'h0000, sw_busy} << `CTL_RESET_BIT);
      `OFS_BASIC_MODE_STATUS:
        rd_data = status_word;
      `OFS_IDENTIFIER_HIGH:
        rd_data = OUI_HIGH;
      `OFS_IDENTIFIER_LOW: begin
        rd_data[`ID_OUI_LOW_MSB:`ID_OUI_LOW_LSB] = OUI_LOW;
        rd_data[`ID_MODEL_MSB:`ID_MODEL_LSB]     = MODEL_NUM;
        rd_data[`ID_REV_MSB:`ID_REV_LSB]         = MODEL_REV;
      end
      `OFS_NEG_ADVERTISE:
        rd_data = negotiation_advertise_q;
      `OFS_PARTNER_ABILITY:
        rd_data = partner_ability_q;
      `OFS_NEG_EXPANSION:
        rd_data = {11'h000, expansion_bits} & `EXPANSION_MASK;
      `OFS_NEXT_PAGE_TRANSMIT:
        rd_data = next_page_transmit_q;
      `OFS_LINK_STATUS_SUMMARY:
        rd_data = link_summary & `SUMMARY_MASK;
      `OFS_FALSE_CARRIER_CNT:
        rd_data = {8'h00, false_carrier_q};
      `OFS_RECEIVE_ERROR_CNT:
        rd_data = {8'h00, receive_error_q};
      `OFS_CODING_SUBLAYER_CFG:
        rd_data = coding_sublayer_config_q;
      `OFS_TRANSCEIVER_CONTROL:
        rd_data = transceiver_control_q | {11'h000, strap_lat_q[7:3]};
      `OFS_TEN_BASE_STAT_CTRL:
        rd_data = ten_base_status_control_q |
                  ({15'h0000, polarity_inv} << `TEN_BASE_POL_BIT);
      `OFS_DRIVER_TEST_CONTROL:
        rd_data = driver_test_control_q;
      default:
        rd_data = 16'h0000;
    endcase
  end

endmodule // phy_mgmt_regs

`default_nettype wire

// *** pkg/phy_mgmt_regs.vh ***
`ifndef PHY_MGMT_REGS_VH
`define PHY_MGMT_REGS_VH

// ****************************************
// register offsets (5-bit management address)
// ****************************************
`define OFS_BASIC_MODE_CONTROL  5'h00
`define OFS_BASIC_MODE_STATUS   5'h01
`define OFS_IDENTIFIER_HIGH     5'h02
`define OFS_IDENTIFIER_LOW      5'h03
`define OFS_NEG_ADVERTISE       5'h04
`define OFS_PARTNER_ABILITY     5'h05
`define OFS_NEG_EXPANSION       5'h06
`define OFS_NEXT_PAGE_TRANSMIT  5'h07
`define OFS_LINK_STATUS_SUMMARY 5'h10
`define OFS_FALSE_CARRIER_CNT   5'h14
`define OFS_RECEIVE_ERROR_CNT   5'h15
`define OFS_CODING_SUBLAYER_CFG 5'h16
`define OFS_TRANSCEIVER_CONTROL 5'h19
`define OFS_TEN_BASE_STAT_CTRL  5'h1A
`define OFS_DRIVER_TEST_CONTROL 5'h1B

// ****************************************
// basic mode control field positions
// ****************************************
`define CTL_RESET_BIT       15
`define CTL_LOOPBACK_BIT    14
`define CTL_SPEED_BIT       13
`define CTL_AN_ENABLE_BIT   12
`define CTL_POWER_DOWN_BIT  11
`define CTL_ISOLATE_BIT     10
`define CTL_AN_RESTART_BIT  9
`define CTL_DUPLEX_BIT      8
`define CTL_COL_TEST_BIT    7

// ****************************************
// basic mode status field positions and fixed bits
// ****************************************
`define STS_AN_COMPLETE_BIT 5
`define STS_REMOTE_FLT_BIT  4
`define STS_LINK_BIT        2
`define STS_JABBER_BIT      1
`define STS_FIXED_CAPS      16'h7849

// ****************************************
// identifier fields
// ****************************************
`define ID_OUI_LOW_MSB      15
`define ID_OUI_LOW_LSB      10
`define ID_MODEL_MSB        9
`define ID_MODEL_LSB        4
`define ID_REV_MSB          3
`define ID_REV_LSB          0

// ****************************************
// reset values and writable masks
// ****************************************
`define ADVERTISE_RST       16'h01E1
`define ADVERTISE_MASK      16'hA7FF
`define NEXT_PAGE_RST       16'h2001
`define NEXT_PAGE_MASK      16'hBFFF
`define PARTNER_RST         16'h0000
`define CODING_CFG_RST      16'h0000
`define CODING_CFG_MASK     16'h1F27
`define XCVR_CTRL_RST       16'h0000
`define XCVR_CTRL_MASK      16'h0FE0
`define TEN_BASE_RST        16'h0000
`define TEN_BASE_MASK       16'h01C3
`define TEN_BASE_POL_BIT    4
`define DRV_TEST_RST        16'h0000
`define DRV_TEST_MASK       16'hFF1F
`define SUMMARY_MASK        16'h3F7F
`define EXPANSION_MASK      16'h001F
`define COUNTER_MAX         8'hFF

// ****************************************
// timing
// ****************************************
`define CLK_MHZ             125
`define HW_RESET_MIN_US     160
`define SW_RESET_US         160
`define STATION_WAIT_US     500

`endif

// *** hw/reset_ctl.v ***
`timescale 1ns/1ps
`default_nettype none

module reset_ctl #(
  parameter SW_RESET_CYCLES = 20000
) (
  // clock and reset
  input  wire clk,
  input  wire srst,
  // reset sources
  input  wire reset_pin_n,
  input  wire sw_req,
  // result
  output reg  core_rst_q,
  output reg  sw_busy_q
);

  reg        pin_s1_q;
  reg        pin_s2_q;
  reg [14:0] sw_cnt_q;

  // ****************************************
  // pin synchroniser
  // ****************************************
  always @(posedge clk) begin
    pin_s1_q <= reset_pin_n;
    pin_s2_q <= pin_s1_q;
  end

  // ****************************************
  // software reset timer
  // ****************************************
  always @(posedge clk) begin
    if (srst || !pin_s2_q) begin
      sw_busy_q <= 1'b0;
      sw_cnt_q  <= 15'h0000;
    end else if (!sw_busy_q) begin
      if (sw_req) begin
        sw_busy_q <= 1'b1;
        sw_cnt_q  <= SW_RESET_CYCLES[14:0] - 15'h0001;
      end
    end else if (sw_cnt_q == 15'h0000) begin
      sw_busy_q <= 1'b0;
    end else begin
      sw_cnt_q <= sw_cnt_q - 15'h0001;
    end
  end

  // ****************************************
  // core reset, released on a clock edge
  // ****************************************
  // a low pin resets three clocks later, at any time; the driver keeps it long
  always @(posedge clk) begin
    core_rst_q <= srst | ~pin_s2_q | sw_busy_q;
  end

endmodule // reset_ctl

`default_nettype wire

// *** hw/mdio_serial.v ***
`timescale 1ns/1ps
`default_nettype none

module mdio_serial (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // management pins
  input  wire        mdc,
  input  wire        mdio_in,
  output reg         mdio_out_q,
  output reg         mdio_oe_n_q,
  // register side
  input  wire [4:0]  phy_addr,
  input  wire [15:0] rd_data,
  output reg  [4:0]  reg_addr_q,
  output reg  [15:0] wr_data_q,
  output reg         wr_stb_q,
  output reg         rd_stb_q
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ST   = 5'h02;
  localparam [4:0] S_HDR  = 5'h04;
  localparam [4:0] S_TA   = 5'h08;
  localparam [4:0] S_DATA = 5'h10;

  reg        mdc_s1_q;
  reg        mdc_s2_q;
  reg        mdc_s3_q;
  reg        dio_s1_q;
  reg        dio_s2_q;
  reg [4:0]  state_q;
  reg [10:0] hdr_q;
  reg [3:0]  cnt_q;
  reg        is_rd_q;
  reg        hit_q;
  reg [15:0] shift_q;
  wire       rise;
  wire       bit_in;
  wire [11:0] full_hdr;

  // ****************************************
  // pin sampling
  // ****************************************
  always @(posedge clk) begin
    mdc_s1_q <= mdc;
    mdc_s2_q <= mdc_s1_q;
    mdc_s3_q <= mdc_s2_q;
    dio_s1_q <= mdio_in;
    dio_s2_q <= dio_s1_q;
  end

  assign rise     = mdc_s2_q & ~mdc_s3_q;
  assign bit_in   = dio_s2_q;
  assign full_hdr = {hdr_q, bit_in};

  // ****************************************
  // frame engine
  // ****************************************
  // preamble is optional: any 0 then 1 starts a frame
  always @(posedge clk) begin
    if (rst) begin
      state_q     <= S_IDLE;
      hdr_q       <= 11'h000;
      cnt_q       <= 4'h0;
      is_rd_q     <= 1'b0;
      hit_q       <= 1'b0;
      shift_q     <= 16'h0000;
      reg_addr_q  <= 5'h00;
      wr_data_q   <= 16'h0000;
      wr_stb_q    <= 1'b0;
      rd_stb_q    <= 1'b0;
      mdio_out_q  <= 1'b1;
      mdio_oe_n_q <= 1'b1;
    end else begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (rise) begin
        case (state_q)
          S_IDLE: begin
            if (!bit_in)
              state_q <= S_ST;
          end
          S_ST: begin
            if (bit_in) begin
              state_q <= S_HDR;
              cnt_q   <= 4'h0;
            end
          end
          S_HDR: begin
            hdr_q <= full_hdr[10:0];
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'hB) begin
              is_rd_q    <= (full_hdr[11:10] == 2'b10);
              hit_q      <= (full_hdr[9:5] == phy_addr);
              reg_addr_q <= full_hdr[4:0];
              cnt_q      <= 4'h0;
              if (full_hdr[11:10] == 2'b10 || full_hdr[11:10] == 2'b01)
                state_q <= S_TA;
              else
                state_q <= S_IDLE;
            end
          end
          S_TA: begin
            if (cnt_q == 4'h0) begin
              cnt_q <= 4'h1;
              if (is_rd_q && hit_q) begin
                // capture before read side effects clear anything
                shift_q     <= rd_data;
                rd_stb_q    <= 1'b1;
                mdio_oe_n_q <= 1'b0;
                mdio_out_q  <= 1'b0;
              end
            end else begin
              cnt_q      <= 4'h0;
              state_q    <= S_DATA;
              mdio_out_q <= shift_q[15];
              shift_q    <= {shift_q[14:0], 1'b0};
            end
          end
          S_DATA: begin
            cnt_q <= cnt_q + 4'h1;
            if (is_rd_q) begin
              mdio_out_q <= shift_q[15];
              shift_q    <= {shift_q[14:0], 1'b0};
              if (cnt_q == 4'hF) begin
                mdio_oe_n_q <= 1'b1;
                mdio_out_q  <= 1'b1;
                state_q     <= S_IDLE;
              end
            end else begin
              wr_data_q <= {wr_data_q[14:0], bit_in};
              if (cnt_q == 4'hF) begin
                wr_stb_q <= hit_q;
                state_q  <= S_IDLE;
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // mdio_serial

`default_nettype wire

// *** dv/phy_mgmt_regs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module phy_mgmt_regs_chk #(
  parameter SW_RESET_CYCLES = 50
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        reset_pin_n,
  // watched outputs
  input wire logic        mdio_out,
  input wire logic        mdio_oe_n,
  input wire logic        core_rst,
  input wire logic [15:0] basic_mode_control_q,
  input wire logic        an_restart_q,
  input wire logic [15:0] negotiation_advertise_q,
  input wire logic [15:0] next_page_transmit_q,
  input wire logic [15:0] ten_base_status_control_q
);
  // run length of a software reset; pin and srst restart it
  logic [15:0] rst_len_q;
  always @(posedge clk) begin
    if (srst || !reset_pin_n || !core_rst)
      rst_len_q <= 16'h0000;
    else
      rst_len_q <= rst_len_q + 16'h0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_pin_rst_core: assert property ($fell(reset_pin_n) |-> ##[1:4] core_rst)
    else $error("core reset missed a pin reset");
  a_pin_release: assert property ($rose(reset_pin_n) |-> ##[2:5] !core_rst)
    else $error("core reset not released after pin");
  a_rst_adv_dflt: assert property (core_rst |=>
    negotiation_advertise_q == 16'h01E1) else $error("advertise not default");
  a_rst_npt_dflt: assert property (core_rst |=>
    next_page_transmit_q == 16'h2001) else $error("next page not default");
  a_rst_ctl_clr: assert property (core_rst |=>
    (basic_mode_control_q & 16'hCEFF) == 16'h0000)
    else $error("control not default");
  a_rst_pin_idle: assert property (core_rst ##1 core_rst |->
    mdio_oe_n && mdio_out) else $error("data pin driven in reset");
  a_sw_rst_len: assert property (rst_len_q <= SW_RESET_CYCLES + 8)
    else $error("software reset too long");
  a_self_clear: assert property (basic_mode_control_q[15] == 1'b0)
    else $error("reset bit stuck");
  a_restart_pulse: assert property (an_restart_q |=> !an_restart_q)
    else $error("restart pulse too long");
  a_adv_wmask: assert property ((negotiation_advertise_q & 16'h5800) == 0)
    else $error("advertise reserved bits set");
  a_ten_wmask: assert property ((ten_base_status_control_q & 16'hFE3C) == 0)
    else $error("10base control reserved bits set");
endmodule // phy_mgmt_regs_chk

`default_nettype wire

// *** dv/mdio_station.sv ***
`timescale 1ns/1ps
`default_nettype none

module mdio_station (
  // device side
  input  wire logic dev_out,
  input  wire logic dev_oe_n,
  // station pins
  output var  logic mdc,
  output wire logic line
);
  logic en = 1'b0;
  logic dat = 1'b1;
  logic smp;

  initial mdc = 1'b0;
  // released line floats to the pull-up
  assign line = !dev_oe_n ? dev_out : (en ? dat : 1'b1);

  task automatic bit_tx(input logic b, input logic e);
    begin
      en = e;
      dat = b;
      #80 mdc = 1'b1;
      smp = line;
      #80 mdc = 1'b0;
    end
  endtask

  // no preamble; mdc stands low between frames
  task automatic xfer(input logic rd, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] q);
    logic [15:0] h;
    integer i;
    begin
      h = {2'b01, rd, !rd, pa, ra, 2'b10};
      for (i = 15; i >= 0; i--)
        bit_tx(h[i], !(rd && i < 2));
      for (i = 15; i >= 0; i--) begin
        bit_tx(wd[i], !rd);
        q[i] = smp;
      end
      en = 1'b0;
    end
  endtask
endmodule // mdio_station

`default_nettype wire

// *** dv/tb_phy_mgmt_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_phy_mgmt_regs;
  localparam SW_CYC = 50;
  // 160 us and 500 us scaled to the shortened reset
  localparam PIN_CYC = SW_CYC;
  localparam WAIT_CYC = SW_CYC * 500 / 160;
  localparam [4:0] PA = 5'h05;
  // arbitrary identity values
  localparam [15:0] OUI_H = 16'h0F0F;
  localparam [15:0] ID_LO = 16'hA873;
  localparam logic [4:0] DA [16] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h06, 5'h07, 5'h08, 5'h10, 5'h14, 5'h15, 5'h16, 5'h19, 5'h1A, 5'h1B,
    5'h1C};
  localparam logic [15:0] DV [16] = '{16'h3000, OUI_H, ID_LO, 16'h01E1,
    16'h0000, 16'h001F, 16'h2001, 16'h0000, 16'h3F7F, 16'h0000, 16'h0000,
    16'h0000, 16'h0005, 16'h0010, 16'h0000, 16'h0000};
  localparam logic [4:0] WA [12] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h07,
    5'h08, 5'h10, 5'h16, 5'h19, 5'h1A, 5'h1B, 5'h1F};
  localparam logic [15:0] WV [12] = '{16'h784D, OUI_H, 16'hA7FF, 16'hFFFF,
    16'hBFFF, 16'h0000, 16'h3F7F, 16'h1F27, 16'h0FE5, 16'h01D3, 16'hFF1F,
    16'h0000};

  logic        clk;
  logic        srst;
  logic        reset_pin_n;
  wire logic   mdc;
  wire logic   mdio_in;
  logic        mdio_out;
  logic        mdio_oe_n;
  logic        strap_speed;
  logic        strap_duplex;
  logic        link_up;
  logic        polarity_inv;
  logic        partner_page_stb;
  logic        false_carrier_evt;
  logic        rx_error_evt;
  logic        core_rst;
  logic        an_restart_q;
  logic        rst_seen = 1'b0;
  logic [4:0]  expansion_bits;
  logic [4:0]  sta;
  logic [15:0] partner_page;
  logic [15:0] link_summary;
  logic [15:0] basic_mode_control_q;
  logic [15:0] negotiation_advertise_q;
  logic [15:0] next_page_transmit_q;
  logic [15:0] ten_base_status_control_q;
  logic [15:0] msk;
  logic [15:0] dummy;
  integer      n_mismatch;
  integer      comparisons;
  integer      cyc;
  integer      i;

  phy_mgmt_regs #(.SW_RESET_CYCLES(SW_CYC), .OUI_HIGH(OUI_H),
    .OUI_LOW(6'h2A), .MODEL_NUM(6'h07), .MODEL_REV(4'h3)) i_phy_mgmt_regs (
    .clk, .srst, .reset_pin_n, .mdc, .mdio_in, .mdio_out, .mdio_oe_n,
    .strap_phy_addr(PA), .strap_an_enable(1'b1), .strap_speed, .strap_duplex,
    .an_complete(1'b0), .remote_fault(rx_error_evt), .link_up,
    .jabber(false_carrier_evt), .expansion_bits, .partner_page,
    .partner_page_stb, .link_summary,
    .polarity_inv, .false_carrier_evt, .rx_error_evt, .core_rst,
    .basic_mode_control_q, .an_restart_q, .negotiation_advertise_q,
    .next_page_transmit_q, .coding_sublayer_config_q(),
    .transceiver_control_q(), .ten_base_status_control_q,
    .driver_test_control_q());

  mdio_station i_mdio_station (.dev_out(mdio_out), .dev_oe_n(mdio_oe_n),
    .mdc, .line(mdio_in));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (an_restart_q === 1'b1)
      rst_seen <= 1'b1;
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end

  // ********
  // tasks
  // ********
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    begin
      @(posedge clk) #1;
      i_mdio_station.xfer(1'b0, sta, a, d, dummy);
    end
  endtask

  task automatic rdx(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    begin
      @(posedge clk) #1;
      i_mdio_station.xfer(1'b1, sta, a, 16'h0000, q);
      chk($sformatf("reg %h", a), e, q & msk);
    end
  endtask

  task automatic conclude;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // ********
  // tests
  // ********
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    srst = 1'b1;
    reset_pin_n = 1'b0;
    strap_speed = 1'b1;
    strap_duplex = 1'b0;
    link_up = 1'b1;
    polarity_inv = 1'b1;
    partner_page = 16'h0000;
    partner_page_stb = 1'b0;
    false_carrier_evt = 1'b0;
    rx_error_evt = 1'b0;
    expansion_bits = 5'h1F;
    link_summary = 16'hFFFF;
    sta = PA;
    msk = 16'hFFF9;
    repeat (10) @(posedge clk);
    #1 srst = 1'b0;
    repeat (PIN_CYC - 10) @(posedge clk);
    #1 reset_pin_n = 1'b1;
    repeat (10) @(posedge clk);
    rdx(5'h01, 16'h7849);
    msk = 16'hFFFF;
    rdx(5'h01, 16'h784D);
    for (i = 0; i < 16; i++)
      rdx(DA[i], DV[i]);
    $display("test defaults done");
    for (i = 0; i < 12; i++) begin
      wr(WA[i], 16'hFFFF);
      rdx(WA[i], WV[i]);
    end
    chk("advertise", 16'hA7FF, negotiation_advertise_q);
    chk("next page", 16'hBFFF, next_page_transmit_q);
    chk("10base", 16'h01C3, ten_base_status_control_q);
    sta = PA ^ 5'h01;
    wr(5'h04, 16'h0000);
    rdx(5'h04, 16'hFFFF);
    sta = PA;
    rdx(5'h04, 16'hA7FF);
    $display("test access done");
    @(posedge clk) #1 partner_page = 16'hC5A3;
    partner_page_stb = 1'b1;
    @(posedge clk) #1 partner_page_stb = 1'b0;
    rdx(5'h05, 16'hC5A3);
    for (i = 0; i < 3; i++) begin
      @(posedge clk) #1 false_carrier_evt = 1'b1;
      rx_error_evt = (i < 2);
      @(posedge clk) #1 false_carrier_evt = 1'b0;
      rx_error_evt = 1'b0;
    end
    rdx(5'h01, 16'h785F);
    rdx(5'h01, 16'h784D);
    rdx(5'h14, 16'h0003);
    rdx(5'h14, 16'h0000);
    rdx(5'h15, 16'h0002);
    $display("test events done");
    wr(5'h00, 16'h1200);
    rdx(5'h00, 16'h1000);
    chk("restart", 16'h0001, {15'h0000, rst_seen});
    strap_speed = 1'b0;
    strap_duplex = 1'b1;
    wr(5'h00, 16'h8000);
    chk("sw reset", 16'h0001, {15'h0000, core_rst});
    for (i = 0; i < 200 && core_rst; i++)
      @(posedge clk) #1;
    chk("sw length", 16'h0001, 16'(i >= SW_CYC-12 && i <= SW_CYC));
    repeat (WAIT_CYC) @(posedge clk);
    rdx(5'h00, 16'h1100);
    rdx(5'h04, 16'h01E1);
    $display("test software reset done");
    wr(5'h04, 16'h0000);
    strap_speed = 1'b1;
    strap_duplex = 1'b0;
    @(posedge clk) #1 reset_pin_n = 1'b0;
    repeat (PIN_CYC) @(posedge clk);
    #1 reset_pin_n = 1'b1;
    repeat (10) @(posedge clk);
    rdx(5'h04, 16'h01E1);
    rdx(5'h00, 16'h3000);
    $display("test pin reset done");
    conclude;
  end
endmodule // tb_phy_mgmt_regs

bind phy_mgmt_regs phy_mgmt_regs_chk #(.SW_RESET_CYCLES(SW_RESET_CYCLES))
  i_phy_mgmt_regs_chk (.clk, .srst, .reset_pin_n, .mdio_out, .mdio_oe_n,
  .core_rst, .basic_mode_control_q, .an_restart_q, .negotiation_advertise_q,
  .next_page_transmit_q, .ten_base_status_control_q);

`default_nettype wire
